// ==== rtl/swdbg_map.svh ====
// Constants of the single-wire debug command unit: codes, fields, counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SWDBG_MAP_SVH
`define SWDBG_MAP_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define SWDBG_CMD_TARGET_RESET 8'h18
`define SWDBG_CMD_HALT 8'h90
`define SWDBG_CMD_STATUS_FETCH 8'hE4
`define SWDBG_CMD_CTRL_STORE 8'hC4
`define SWDBG_CMD_MEM_FETCH 8'hE0
`define SWDBG_CMD_MEM_FETCH_FLAGGED 8'hE1
`define SWDBG_CMD_MEM_STORE 8'hC0
`define SWDBG_CMD_MEM_STORE_FLAGGED 8'hC1
`define SWDBG_CMD_MATCH_ADDR_FETCH 8'hE2
`define SWDBG_CMD_MATCH_ADDR_STORE 8'hC2
`define SWDBG_CMD_RESUME 8'h08
`define SWDBG_CMD_SINGLE_STEP 8'h10
`define SWDBG_CMD_BLOCK_FETCH 8'h80
`define SWDBG_CMD_BLOCK_STORE 8'h88

// ----------------------------------------------------------------------
// Status/control byte fields
// ----------------------------------------------------------------------
`define SWDBG_SC_HALT_PERMIT 7
`define SWDBG_SC_BDM_ACTIVE 6
`define SWDBG_SC_BKPT_ENABLE 5
`define SWDBG_SC_FORCE_TAG 4
`define SWDBG_SC_WAIT_STOP 2
`define SWDBG_SC_WAIT_STOP_FAIL 1
`define SWDBG_SC_RESET 8'h00
`define SWDBG_MATCH_RESET 16'h0000

// ----------------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------------
`define SWDBG_ADDR_BITS 14
`define SWDBG_SOFT_RESET_CYCLES 512
`define SWDBG_SYNC_PULSE_CYCLES 128

`endif

// ==== rtl/swdbg_pkg.sv ====
// Types of the single-wire debug command unit.
// Assumes swdbg_map.svh on the include path.
`include "swdbg_map.svh"

package swdbg_pkg;

  typedef enum logic [9:0] {
    SWDBG_S_CODE = 10'h001,
    SWDBG_S_ADDR_HI = 10'h002,
    SWDBG_S_ADDR_LO = 10'h004,
    SWDBG_S_WDATA = 10'h008,
    SWDBG_S_CTRL = 10'h010,
    SWDBG_S_MATCH_HI = 10'h020,
    SWDBG_S_MATCH_LO = 10'h040,
    SWDBG_S_MEM = 10'h080,
    SWDBG_S_TX = 10'h100,
    SWDBG_S_SKIP = 10'h200
  } swdbg_state_t;

  typedef struct packed {
    swdbg_state_t state;
    logic [7:0] cmd;
    logic [13:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] match_hi;
    logic [15:0] match_addr;
    logic halt_permit;
    logic bkpt_enable;
    logic force_tag;
    logic wsf;
    logic [15:0] tx_hold;
    logic [1:0] tx_left;
    logic tx_wait;
    logic tx_load;
    logic mem_req;
    logic mem_we;
    logic mcu_reset;
    logic halt_req;
    logic resume;
    logic step;
    logic bkpt_force;
    logic bkpt_tag;
    logic [7:0] sync_cnt;
  } swdbg_cmd_state_t;

  typedef struct packed {
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [7:0] rx_byte;
    logic rx_stb;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_done;
    logic [9:0] idle_cnt;
    logic idle_armed;
    logic soft_reset;
  } swdbg_link_state_t;

endpackage : swdbg_pkg

// ==== rtl/swdbg_link.sv ====
// Byte framing of the debug link: MSB-first shift in and out, idle watch.
// Assumes a bit-timing layer on the same clock delivers and takes bits.
`timescale 1ns/10ps
`include "swdbg_map.svh"

module swdbg_link
  import swdbg_pkg::*;
#(
  parameter int unsigned SOFT_RESET_CYCLES = `SWDBG_SOFT_RESET_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Host bits
  input wire logic i_rx_valid,
  input wire logic i_rx_bit,
  input wire logic i_host_fall,
  // Bytes to the command unit
  output logic [7:0] o_rx_byte,
  output logic o_rx_stb,
  output logic o_soft_reset,
  // Bytes from the command unit
  input wire logic i_tx_load,
  input wire logic [7:0] i_tx_byte,
  output logic o_tx_valid,
  output logic o_tx_bit,
  input wire logic i_tx_ready,
  output logic o_tx_done
);

  localparam logic [9:0] IDLE_LAST = 10'(SOFT_RESET_CYCLES - 1);

  swdbg_link_state_t st_reg;
  swdbg_link_state_t st_next;

  assign o_rx_byte = st_reg.rx_byte;
  assign o_rx_stb = st_reg.rx_stb;
  assign o_soft_reset = st_reg.soft_reset;
  assign o_tx_valid = (st_reg.tx_cnt != 4'h0);
  assign o_tx_bit = st_reg.tx_sh[7];
  assign o_tx_done = st_reg.tx_done;

  always_comb begin
    st_next = st_reg;
    st_next.rx_stb = 1'b0;
    st_next.tx_done = 1'b0;
    st_next.soft_reset = 1'b0;
    // ------------------------------------------------------------------
    // Receive, first bit lands in the top position
    // ------------------------------------------------------------------
    if (i_rx_valid) begin
      st_next.rx_sh = {st_reg.rx_sh[6:0], i_rx_bit};
      st_next.rx_cnt = st_reg.rx_cnt + 3'h1;
      if (st_reg.rx_cnt == 3'h7) begin
        st_next.rx_byte = {st_reg.rx_sh[6:0], i_rx_bit};
        st_next.rx_stb = 1'b1;
      end
    end
    // ------------------------------------------------------------------
    // Transmit
    // ------------------------------------------------------------------
    if (i_tx_load) begin
      st_next.tx_sh = i_tx_byte;
      st_next.tx_cnt = 4'h8;
    end else if (o_tx_valid && i_tx_ready) begin
      st_next.tx_sh = {st_reg.tx_sh[6:0], 1'b0};
      st_next.tx_cnt = st_reg.tx_cnt - 4'h1;
      st_next.tx_done = (st_reg.tx_cnt == 4'h1);
    end
    // ------------------------------------------------------------------
    // Idle watch: armed by each host falling edge, fires once
    // ------------------------------------------------------------------
    if (i_host_fall) begin
      st_next.idle_cnt = 10'h000;
      st_next.idle_armed = 1'b1;
    end else if (st_reg.idle_armed) begin
      st_next.idle_cnt = st_reg.idle_cnt + 10'h001;
      if (st_reg.idle_cnt == IDLE_LAST) begin
        st_next.idle_armed = 1'b0;
        st_next.soft_reset = 1'b1;
        // Partial bytes are dropped so the next code starts aligned
        st_next.rx_cnt = 3'h0;
        st_next.tx_cnt = 4'h0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

endmodule : swdbg_link

// ==== rtl/swdbg_cmd.sv ====
// Single-wire debug command unit: decodes host commands, drives memory
// and CPU requests, holds the status/control byte and breakpoint match.
// Assumes a bit-timing layer on i_ref_clk and a CPU/memory that answer
// requests with one-cycle acknowledges.
`timescale 1ns/10ps
`include "swdbg_map.svh"

module swdbg_cmd
  import swdbg_pkg::*;
#(
  parameter int unsigned SOFT_RESET_CYCLES = `SWDBG_SOFT_RESET_CYCLES,
  parameter int unsigned SYNC_PULSE_CYCLES = `SWDBG_SYNC_PULSE_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Bit layer of the background pin
  input wire logic i_rx_valid,
  input wire logic i_rx_bit,
  input wire logic i_host_fall,
  input wire logic i_sync_req,
  output logic o_sync_pulse,
  output logic o_tx_valid,
  output logic o_tx_bit,
  input wire logic i_tx_ready,
  // Memory access
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [13:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic i_mem_fail,
  input wire logic [7:0] i_mem_rdata,
  // CPU control
  input wire logic i_cpu_halted,
  input wire logic i_cpu_wait_stop,
  output logic o_mcu_reset,
  output logic o_halt_req,
  output logic o_resume,
  output logic o_step,
  // Breakpoint
  input wire logic [13:0] i_cpu_addr,
  input wire logic i_cpu_addr_valid,
  input wire logic i_opcode_fetch,
  output logic o_bkpt_force,
  output logic o_bkpt_tag,
  // Status/control byte view
  output logic [7:0] o_status_ctrl
);

  localparam logic [7:0] SYNC_LAST = 8'(SYNC_PULSE_CYCLES);

  swdbg_cmd_state_t st_reg;
  swdbg_cmd_state_t st_next;

  logic [7:0] rx_byte;
  logic rx_stb;
  logic soft_reset;
  logic tx_done;
  logic [7:0] status_byte;
  logic addr_hit;

  // ----------------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------------
  swdbg_link #(
    .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)
  ) u_link (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_rx_valid(i_rx_valid),
    .i_rx_bit(i_rx_bit),
    .i_host_fall(i_host_fall),
    .o_rx_byte(rx_byte),
    .o_rx_stb(rx_stb),
    .o_soft_reset(soft_reset),
    .i_tx_load(st_reg.tx_load),
    .i_tx_byte(st_reg.tx_hold[15:8]),
    .o_tx_valid(o_tx_valid),
    .o_tx_bit(o_tx_bit),
    .i_tx_ready(i_tx_ready),
    .o_tx_done(tx_done)
  );

  // ----------------------------------------------------------------------
  // Status byte and outputs
  // ----------------------------------------------------------------------
  always_comb begin
    status_byte = 8'h00;
    status_byte[`SWDBG_SC_HALT_PERMIT] = st_reg.halt_permit;
    status_byte[`SWDBG_SC_BDM_ACTIVE] = i_cpu_halted;
    status_byte[`SWDBG_SC_BKPT_ENABLE] = st_reg.bkpt_enable;
    status_byte[`SWDBG_SC_FORCE_TAG] = st_reg.force_tag;
    status_byte[`SWDBG_SC_WAIT_STOP] = i_cpu_wait_stop;
    status_byte[`SWDBG_SC_WAIT_STOP_FAIL] = st_reg.wsf;
  end

  // Bits 15 and 14 of the match register are stored but never compared
  assign addr_hit = (i_cpu_addr == st_reg.match_addr[13:0]);

  assign o_sync_pulse = (st_reg.sync_cnt != 8'h00);
  assign o_mem_req = st_reg.mem_req;
  assign o_mem_we = st_reg.mem_we;
  assign o_mem_addr = st_reg.addr;
  assign o_mem_wdata = st_reg.wdata;
  assign o_mcu_reset = st_reg.mcu_reset;
  assign o_halt_req = st_reg.halt_req;
  assign o_resume = st_reg.resume;
  assign o_step = st_reg.step;
  assign o_bkpt_force = st_reg.bkpt_force;
  assign o_bkpt_tag = st_reg.bkpt_tag;
  assign o_status_ctrl = status_byte;

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.tx_load = 1'b0;
    st_next.mcu_reset = 1'b0;
    st_next.halt_req = 1'b0;
    st_next.resume = 1'b0;
    st_next.step = 1'b0;

    // Registered compare; disabled breakpoint ignores select and match
    st_next.bkpt_force = st_reg.bkpt_enable && st_reg.force_tag
                         && i_cpu_addr_valid && addr_hit;
    st_next.bkpt_tag = st_reg.bkpt_enable && !st_reg.force_tag
                       && i_opcode_fetch && addr_hit;

    // Reference pulse, independent of the command flow
    if (i_sync_req) begin
      st_next.sync_cnt = SYNC_LAST;
    end else if (st_reg.sync_cnt != 8'h00) begin
      st_next.sync_cnt = st_reg.sync_cnt - 8'h01;
    end

    case (st_reg.state)
      SWDBG_S_CODE: begin
        if (rx_stb) begin
          st_next.cmd = rx_byte;
          case (rx_byte)
            `SWDBG_CMD_TARGET_RESET: begin
              st_next.mcu_reset = 1'b1;
            end
            `SWDBG_CMD_HALT: begin
              st_next.halt_req = st_reg.halt_permit;
            end
            `SWDBG_CMD_STATUS_FETCH: begin
              st_next.tx_hold = {status_byte, 8'h00};
              st_next.tx_left = 2'h1;
              st_next.tx_load = 1'b1;
              st_next.state = SWDBG_S_TX;
            end
            `SWDBG_CMD_CTRL_STORE: begin
              st_next.state = SWDBG_S_CTRL;
            end
            `SWDBG_CMD_MEM_FETCH, `SWDBG_CMD_MEM_FETCH_FLAGGED,
            `SWDBG_CMD_MEM_STORE, `SWDBG_CMD_MEM_STORE_FLAGGED: begin
              st_next.wsf = 1'b0;
              st_next.state = SWDBG_S_ADDR_HI;
            end
            `SWDBG_CMD_MATCH_ADDR_FETCH: begin
              st_next.tx_hold = st_reg.match_addr;
              st_next.tx_left = 2'h2;
              st_next.tx_load = 1'b1;
              st_next.state = SWDBG_S_TX;
            end
            `SWDBG_CMD_MATCH_ADDR_STORE: begin
              st_next.state = SWDBG_S_MATCH_HI;
            end
            `SWDBG_CMD_RESUME: begin
              st_next.resume = i_cpu_halted;
            end
            `SWDBG_CMD_SINGLE_STEP: begin
              st_next.step = i_cpu_halted;
            end
            `SWDBG_CMD_BLOCK_FETCH, `SWDBG_CMD_BLOCK_STORE: begin
              // Running CPU: swallow the fields until the soft reset
              st_next.state = i_cpu_halted ? SWDBG_S_ADDR_HI : SWDBG_S_SKIP;
            end
            default: begin
              st_next.state = SWDBG_S_SKIP;
            end
          endcase
        end
      end
      SWDBG_S_ADDR_HI: begin
        if (rx_stb) begin
          st_next.addr = {rx_byte[5:0], st_reg.addr[7:0]};
          st_next.state = SWDBG_S_ADDR_LO;
        end
      end
      SWDBG_S_ADDR_LO: begin
        if (rx_stb) begin
          st_next.addr = {st_reg.addr[13:8], rx_byte};
          if (st_reg.cmd == `SWDBG_CMD_MEM_FETCH
              || st_reg.cmd == `SWDBG_CMD_MEM_FETCH_FLAGGED
              || st_reg.cmd == `SWDBG_CMD_BLOCK_FETCH) begin
            // Fetch codes start the access now, ahead of the host delay
            st_next.mem_req = 1'b1;
            st_next.mem_we = 1'b0;
            st_next.state = SWDBG_S_MEM;
          end else begin
            st_next.state = SWDBG_S_WDATA;
          end
        end
      end
      SWDBG_S_WDATA: begin
        if (rx_stb) begin
          st_next.wdata = rx_byte;
          st_next.mem_req = 1'b1;
          st_next.mem_we = 1'b1;
          st_next.state = SWDBG_S_MEM;
        end
      end
      SWDBG_S_CTRL: begin
        if (rx_stb) begin
          st_next.bkpt_enable = rx_byte[`SWDBG_SC_BKPT_ENABLE];
          st_next.force_tag = rx_byte[`SWDBG_SC_FORCE_TAG];
          // Permit bit frozen while halted to avoid a self-forbidding halt
          if (!i_cpu_halted) begin
            st_next.halt_permit = rx_byte[`SWDBG_SC_HALT_PERMIT];
          end
          st_next.state = SWDBG_S_CODE;
        end
      end
      SWDBG_S_MATCH_HI: begin
        if (rx_stb) begin
          st_next.match_hi = rx_byte;
          st_next.state = SWDBG_S_MATCH_LO;
        end
      end
      SWDBG_S_MATCH_LO: begin
        if (rx_stb) begin
          st_next.match_addr = {st_reg.match_hi, rx_byte};
          st_next.state = SWDBG_S_CODE;
        end
      end
      SWDBG_S_MEM: begin
        if (i_mem_ack) begin
          st_next.mem_req = 1'b0;
          st_next.rdata = i_mem_rdata;
          st_next.wsf = st_reg.wsf | i_mem_fail;
          case (st_reg.cmd)
            `SWDBG_CMD_MEM_FETCH, `SWDBG_CMD_BLOCK_FETCH: begin
              st_next.tx_hold = {i_mem_rdata, 8'h00};
              st_next.tx_left = 2'h1;
              st_next.tx_load = 1'b1;
              st_next.state = SWDBG_S_TX;
            end
            `SWDBG_CMD_MEM_FETCH_FLAGGED: begin
              st_next.tx_hold = {status_byte, i_mem_rdata};
              st_next.tx_hold[8 + `SWDBG_SC_WAIT_STOP_FAIL] =
                st_reg.wsf | i_mem_fail;
              st_next.tx_left = 2'h2;
              st_next.tx_load = 1'b1;
              st_next.state = SWDBG_S_TX;
            end
            `SWDBG_CMD_MEM_STORE_FLAGGED: begin
              st_next.tx_hold = {status_byte, 8'h00};
              st_next.tx_hold[8 + `SWDBG_SC_WAIT_STOP_FAIL] =
                st_reg.wsf | i_mem_fail;
              st_next.tx_left = 2'h1;
              st_next.tx_load = 1'b1;
              st_next.state = SWDBG_S_TX;
            end
            `SWDBG_CMD_BLOCK_STORE: begin
              st_next.addr = st_reg.addr + 14'h0001;
              st_next.state = SWDBG_S_WDATA;
            end
            default: begin
              st_next.state = SWDBG_S_CODE;
            end
          endcase
        end
      end
      SWDBG_S_TX: begin
        if (tx_done) begin
          st_next.tx_hold = {st_reg.tx_hold[7:0], 8'h00};
          st_next.tx_left = st_reg.tx_left - 2'h1;
          if (st_reg.tx_left == 2'h2) begin
            st_next.tx_load = 1'b1;
          end else if (st_reg.cmd == `SWDBG_CMD_BLOCK_FETCH) begin
            st_next.addr = st_reg.addr + 14'h0001;
            st_next.mem_req = 1'b1;
            st_next.mem_we = 1'b0;
            st_next.state = SWDBG_S_MEM;
          end else begin
            st_next.state = SWDBG_S_CODE;
          end
        end
      end
      SWDBG_S_SKIP: begin
        st_next.state = SWDBG_S_SKIP;
      end
      default: begin
        st_next.state = SWDBG_S_CODE;
      end
    endcase

    // Soft reset ends any command, including the endless block ones
    if (soft_reset) begin
      st_next.state = SWDBG_S_CODE;
      st_next.mem_req = 1'b0;
      st_next.tx_left = 2'h0;
      st_next.tx_load = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_reg <= '0;
      st_reg.state <= SWDBG_S_CODE;
      st_reg.match_addr <= `SWDBG_MATCH_RESET;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

endmodule : swdbg_cmd

// ==== tb/swdbg_host_model.sv ====
// Debug host pod model: sends and takes link bytes bit by bit, MSB first.
// Assumes the command unit's bit-layer ports on the same clock.
`timescale 1ns/10ps

module swdbg_host_model (
  // Clock
  input wire logic i_ref_clk,
  // Bit layer
  output logic o_rx_valid,
  output logic o_rx_bit,
  output logic o_host_fall,
  output logic o_tx_ready,
  input wire logic i_tx_valid,
  input wire logic i_tx_bit
);
  // ----------------------------------------------------------------
  // Host side of the link
  // ----------------------------------------------------------------
  initial begin
    o_rx_valid = 1'b0;
    o_rx_bit = 1'b1;
    o_host_fall = 1'b0;
    o_tx_ready = 1'b0;
  end

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge i_ref_clk);
      o_rx_valid = 1'b1;
      o_host_fall = 1'b1;
      o_rx_bit = b[i];
      @(negedge i_ref_clk);
      o_rx_valid = 1'b0;
      o_host_fall = 1'b0;
      // Released line shows the inverse, not a stale bit
      o_rx_bit = ~b[i];
    end
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] b);
    int n;
    for (int i = 7; i >= 0; i--) begin
      n = 0;
      @(negedge i_ref_clk);
      while (i_tx_valid !== 1'b1 && n < 300) begin
        @(negedge i_ref_clk);
        n++;
      end
      b[i] = i_tx_bit;
      o_tx_ready = 1'b1;
      o_host_fall = 1'b1;
      @(negedge i_ref_clk);
      o_tx_ready = 1'b0;
      o_host_fall = 1'b0;
    end
  endtask : recv_byte

  // Delay points and soft-reset idle
  task automatic pause(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : pause
endmodule : swdbg_host_model

// ==== tb/swdbg_cmd_properties.sv ====
// Checker of the command unit, bound to its top ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps

module swdbg_cmd_properties #(
  parameter int unsigned SYNC_PULSE_CYCLES = 128,
  parameter int unsigned SOFT_RESET_CYCLES = 512
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_host_fall,
  input wire logic i_tx_ready,
  input wire logic o_tx_valid,
  input wire logic o_tx_bit,
  input wire logic o_sync_pulse,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [13:0] o_mem_addr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic i_cpu_halted,
  input wire logic i_cpu_addr_valid,
  input wire logic i_opcode_fetch,
  input wire logic o_mcu_reset,
  input wire logic o_halt_req,
  input wire logic o_resume,
  input wire logic o_step,
  input wire logic o_bkpt_force,
  input wire logic o_bkpt_tag,
  input wire logic [7:0] o_status_ctrl
);
  // ----------------------------------------------------------------
  // Sync pulse length counter
  // ----------------------------------------------------------------
  logic [7:0] sync_len_reg;
  logic [7:0] sync_len_next;
  always_comb sync_len_next = o_sync_pulse ? sync_len_reg + 8'h01 : 8'h00;
  always_ff @(posedge i_ref_clk) sync_len_reg <= i_srst ? 8'h00 : sync_len_next;
  // Cycles since the last host fall; a soft reset may cut a pending bit
  int unsigned idle_len_reg;
  always_ff @(posedge i_ref_clk) begin
    idle_len_reg <= (i_srst || i_host_fall) ? 32'h0 : idle_len_reg + 32'h1;
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  property p_tx_hold;
    o_tx_valid && !i_tx_ready |=> $stable(o_tx_bit)
      && (o_tx_valid || idle_len_reg == SOFT_RESET_CYCLES);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx bit moved");
  property p_mem_hold;
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wdata);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("mem req moved");
  property p_halt_permit;
    o_halt_req |-> $past(o_status_ctrl[7]);
  endproperty
  a_halt_permit: assert property (p_halt_permit) else $error("halt w/o permit");
  property p_halt_only;
    o_resume || o_step |-> $past(i_cpu_halted);
  endproperty
  a_halt_only: assert property (p_halt_only) else $error("run cmd while running");
  property p_reset_pulse;
    o_mcu_reset |=> !o_mcu_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse long");
  property p_force;
    o_bkpt_force |-> $past(o_status_ctrl[4]) && $past(i_cpu_addr_valid);
  endproperty
  a_force: assert property (p_force) else $error("force w/o cause");
  property p_tag;
    o_bkpt_tag |-> !$past(o_status_ctrl[4]) && $past(i_opcode_fetch);
  endproperty
  a_tag: assert property (p_tag) else $error("tag w/o cause");
  property p_disabled;
    !o_status_ctrl[5] |=> !o_bkpt_force && !o_bkpt_tag;
  endproperty
  a_disabled: assert property (p_disabled) else $error("bkpt while off");
  property p_sync_len;
    $fell(o_sync_pulse) |-> 32'(sync_len_reg) == SYNC_PULSE_CYCLES;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync width");
endmodule : swdbg_cmd_properties

bind swdbg_cmd swdbg_cmd_properties #(.SYNC_PULSE_CYCLES(SYNC_PULSE_CYCLES),
  .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_props (
  .i_ref_clk, .i_srst, .i_host_fall, .i_tx_ready, .o_tx_valid, .o_tx_bit, .o_sync_pulse,
  .o_mem_req,
  .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_cpu_halted, .i_cpu_addr_valid,
  .i_opcode_fetch, .o_mcu_reset, .o_halt_req, .o_resume, .o_step, .o_bkpt_force,
  .o_bkpt_tag, .o_status_ctrl);

// ==== tb/swdbg_cmd_tb_top.sv ====
// Testbench of the command unit: host model, memory responder, checks.
// Assumes shortened idle and sync counts for a short run.
`timescale 1ns/10ps

module swdbg_cmd_tb_top;
  import swdbg_pkg::*;
  logic clk, srst, rxv, rxb, fall, txr, txv, txb, sreq, sp, req, we, ack, fail, hlt;
  logic av, of, mrst, hreq, res, stp, frc, tag, ce, ws;
  logic [13:0] ma, ca;
  logic [7:0] wd, rd, sc, b;
  logic [7:0] mem [64];
  int ev_n [7];
  int fail_count = 0;
  int tests_run = 0;
  wire logic [6:0] ev = {sp, tag, frc, mrst, stp, res, hreq};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  swdbg_cmd #(.SOFT_RESET_CYCLES(32), .SYNC_PULSE_CYCLES(8)) dut (
    .i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .i_rx_valid(rxv), .i_rx_bit(rxb),
    .i_host_fall(fall), .i_sync_req(sreq), .o_sync_pulse(sp), .o_tx_valid(txv),
    .o_tx_bit(txb), .i_tx_ready(txr), .o_mem_req(req), .o_mem_we(we), .o_mem_addr(ma),
    .o_mem_wdata(wd), .i_mem_ack(ack), .i_mem_fail(fail), .i_mem_rdata(rd),
    .i_cpu_halted(hlt), .i_cpu_wait_stop(ws), .o_mcu_reset(mrst), .o_halt_req(hreq),
    .o_resume(res), .o_step(stp), .i_cpu_addr(ca), .i_cpu_addr_valid(av),
    .i_opcode_fetch(of), .o_bkpt_force(frc), .o_bkpt_tag(tag), .o_status_ctrl(sc));

  swdbg_host_model h (.i_ref_clk(clk), .o_rx_valid(rxv), .o_rx_bit(rxb),
    .o_host_fall(fall), .o_tx_ready(txr), .i_tx_valid(txv), .i_tx_bit(txb));

  // ----------------------------------------------------------------
  // Memory responder and event counters
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    ack <= req && !ack;
    rd <= mem[ma[5:0]];
    if (req && !ack && we) mem[ma[5:0]] <= wd;
  end
  always @(negedge clk) for (int k = 0; k < 7; k++) if (ev[k] === 1'b1) ev_n[k]++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tx16(input logic [15:0] v);
    h.send_byte(v[15:8]);
    h.send_byte(v[7:0]);
  endtask : tx16
  task automatic rx8(input logic [7:0] e);
    h.recv_byte(b);
    chk({8'h00, b}, {8'h00, e});
  endtask : rx8
  task automatic cyc();
    @(negedge clk);
    av = 1'b1;
    of = 1'b1;
    @(negedge clk);
    av = 1'b0;
    of = 1'b0;
    h.pause(3);
  endtask : cyc
  task automatic ctl(input logic [7:0] v);
    h.send_byte(8'hC4);
    h.send_byte(v);
    h.pause(4);
  endtask : ctl

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  initial begin
    #400000;
    fail_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {srst, ce} = 2'b11;
    {sreq, fail, hlt, av, of, ws} = '0;
    ca = 14'h0123;
    for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'h5A;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    h.send_byte(8'hE4);
    rx8(8'h00);
    h.send_byte(8'hE2);
    rx8(8'h00);
    rx8(8'h00);
    h.send_byte(8'h90);
    h.pause(16);
    chk(16'(ev_n[0]), 16'h0000);
    sreq = 1'b1;
    @(negedge clk);
    sreq = 1'b0;
    h.pause(20);
    chk(16'(ev_n[6]), 16'h0008);
    $display("test 1 done");
    h.send_byte(8'hC2);
    tx16(16'hC123);
    h.send_byte(8'hE2);
    rx8(8'hC1);
    rx8(8'h23);
    ctl(8'hA0);
    cyc();
    ctl(8'h80);
    cyc();
    chk(16'(ev_n[5]), 16'h0001);
    ctl(8'hB0);
    h.send_byte(8'hE4);
    rx8(8'hB0);
    chk({8'h00, sc}, 16'h00B0);
    cyc();
    chk(16'(ev_n[4]), 16'h0001);
    ca = 14'h0124;
    cyc();
    ca = 14'h0123;
    ce = 1'b0;
    cyc();
    ce = 1'b1;
    chk(16'(ev_n[4]), 16'h0001);
    h.send_byte(8'h08);
    h.pause(16);
    chk(16'(ev_n[1]), 16'h0000);
    $display("test 2 done");
    h.send_byte(8'h90);
    h.pause(16);
    chk(16'(ev_n[0]), 16'h0001);
    hlt = 1'b1;
    h.send_byte(8'h18);
    h.pause(16);
    chk(16'(ev_n[3]), 16'h0001);
    h.send_byte(8'hC0);
    tx16(16'hC005);
    h.send_byte(8'hA5);
    h.pause(16);
    chk({8'h00, mem[5]}, 16'h00A5);
    h.send_byte(8'hE0);
    tx16(16'h4005);
    h.pause(16);
    rx8(8'hA5);
    fail = 1'b1;
    h.send_byte(8'hE1);
    tx16(16'h0007);
    h.pause(16);
    rx8(8'hF2);
    rx8(8'h5D);
    fail = 1'b0;
    h.send_byte(8'hC1);
    tx16(16'h0006);
    h.send_byte(8'h3C);
    h.pause(16);
    rx8(8'hF0);
    chk({8'h00, mem[6]}, 16'h003C);
    h.send_byte(8'h10);
    h.pause(16);
    chk(16'(ev_n[2]), 16'h0001);
    $display("test 3 done");
    h.send_byte(8'h80);
    tx16(16'h0010);
    h.pause(16);
    rx8(8'h4A);
    h.pause(16);
    rx8(8'h4B);
    h.pause(40);
    h.send_byte(8'h88);
    tx16(16'h0020);
    h.send_byte(8'h31);
    h.pause(16);
    h.send_byte(8'h32);
    h.pause(40);
    chk({mem[32], mem[33]}, 16'h3132);
    h.send_byte(8'h08);
    h.pause(16);
    chk(16'(ev_n[1]), 16'h0001);
    h.send_byte(8'h55);
    h.send_byte(8'h18);
    h.pause(40);
    chk(16'(ev_n[3]), 16'h0001);
    ctl(8'h00);
    ws = 1'b1;
    h.send_byte(8'hE4);
    rx8(8'hC4);
    $display("test 4 done");
    test_done();
  end
endmodule : swdbg_cmd_tb_top
